// [include/gtm_map.svh]
// register offsets, field positions, reset values and rates of the general timer
`ifndef GTM_MAP_SVH
`define GTM_MAP_SVH

// register byte offsets
`define GTM_CFG_OFS      8'h00
`define GTM_AMODE_OFS    8'h04
`define GTM_BMODE_OFS    8'h08
`define GTM_CTL_OFS      8'h0C
`define GTM_IMR_OFS      8'h18
`define GTM_RIS_OFS      8'h1C
`define GTM_MIS_OFS      8'h20
`define GTM_ICR_OFS      8'h24
`define GTM_AILR_OFS     8'h28
`define GTM_BILR_OFS     8'h2C
`define GTM_AMATCH_OFS   8'h30
`define GTM_BMATCH_OFS   8'h34
`define GTM_APR_OFS      8'h38
`define GTM_BPR_OFS      8'h3C
`define GTM_ACNT_OFS     8'h48
`define GTM_BCNT_OFS     8'h4C

// configuration encodings
`define GTM_CFG_T32_V    3'h0
`define GTM_CFG_RTC_V    3'h1
`define GTM_CFG_SPLIT_V  3'h4

// mode field encodings
`define GTM_MODE_ONE_V   2'h1
`define GTM_MODE_PER_V   2'h2

// control bits, per half at a stride of 8, except rtc override which exists in the low half only
`define GTM_CTL_EN       0
`define GTM_CTL_STALL    1
`define GTM_CTL_RTCOVR   4
`define GTM_CTL_OTE      5
`define GTM_HALF_STRIDE  8
`define GTM_CTL_MASK     16'h2333

// interrupt bits: time-out per half at stride 8, rtc match
`define GTM_INT_TO       0
`define GTM_INT_RTC      3
`define GTM_INT_MASK     16'h0109

// reset and load values
`define GTM_CFG_RST      3'h0
`define GTM_CNT_RST      16'hFFFF
`define GTM_PSC_RST      8'h00
`define GTM_RTC_FIRST    32'h0000_0001

// rtc input and tick rates in Hz
`define GTM_RTC_IN_HZ    32768
`define GTM_RTC_TICK_HZ  1

`endif

// [include/gtm_pkg.sv]
// types shared by the general timer
package gtm_pkg;
`include "gtm_map.svh"

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } gtm_avreq_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } gtm_avrsp_s;

  typedef enum logic [2:0] {
    GTM_CFG_T32   = `GTM_CFG_T32_V,
    GTM_CFG_RTC   = `GTM_CFG_RTC_V,
    GTM_CFG_SPLIT = `GTM_CFG_SPLIT_V
  } gtm_cfg_e;

  typedef enum logic [1:0] {
    GTM_MODE_ONESHOT  = `GTM_MODE_ONE_V,
    GTM_MODE_PERIODIC = `GTM_MODE_PER_V
  } gtm_mode_e;
endpackage

// [rtl/gtm_timer.sv]
// general timer block: two 16-bit halves, 32-bit timer and 32-bit rtc modes
module gtm_timer
  import gtm_pkg::*;
#(
  parameter int RTC_DIV = `GTM_RTC_IN_HZ / `GTM_RTC_TICK_HZ
)(
  // clock, enable and reset
  input  wire logic       ref_clk,
  input  wire logic       clkEn,
  input  wire logic       resetn,
  // register bus
  input  wire gtm_avreq_s avReq,
  output gtm_avrsp_s      avRsp,
  // pins and system signals
  input  wire logic       capCmpPinZero,
  input  wire logic       debugHalt,
  // outputs to the system
  output logic            adcTrigger,
  output logic            irq
);

  // configuration and control state
  logic [2:0]        cfg;
  logic [1:0][1:0]   modeFld;
  logic [15:0]       ctl;
  logic [15:0]       imr;
  logic [15:0]       ris;
  logic [1:0][15:0]  ilr;
  logic [1:0][15:0]  match;
  logic [1:0][15:0]  cnt;
  logic [1:0][7:0]   pr;
  logic [1:0][7:0]   psc;
  logic [1:0]        ldPend;
  logic              rtcSeen;

  // next values and events
  logic [1:0][15:0]  next_cnt;
  logic [1:0][7:0]   next_psc;
  logic [15:0]       next_ris;
  logic [1:0]        toEv;
  logic              rtcEv;
  logic [15:0]       splitCnt [2];
  logic [7:0]        splitPsc [2];
  logic              splitTo  [2];

  // synchronisers and rtc divider
  logic              haltMeta;
  logic              haltSync;
  logic              pinMeta;
  logic              pinSync;
  logic              pinLast;
  logic [15:0]       rtcDiv;
  logic              rtcTick;

  // bus helpers
  logic [31:0]       rdMux;
  logic [31:0]       wrWord;
  logic              wrNow;
  logic              is32;
  logic              isRtc;
  logic              rtcStall;

  // byte-lane merge of write data over the current value
  function automatic logic [31:0] mergeBytes(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[8*i +: 8] = wd[8*i +: 8];
    end
    return res;
  endfunction

  // mode decode
  assign isRtc = (cfg == GTM_CFG_RTC);
  assign is32  = (cfg == GTM_CFG_T32) || isRtc;

  // write takes effect at the edge where waitrequest is seen low
  assign wrNow  = clkEn && avReq.write && !avRsp.waitrequest;
  assign wrWord = mergeBytes(rdMux, avReq.writedata, avReq.byteenable);

  // rtc stalls only when a stall enable is set and override is clear
  assign rtcStall = haltSync && !ctl[`GTM_CTL_RTCOVR] &&
                    (ctl[`GTM_CTL_STALL] || ctl[`GTM_HALF_STRIDE + `GTM_CTL_STALL]);

  // halt and capture pin synchronisers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      haltMeta <= 1'b0;
      haltSync <= 1'b0;
      pinMeta  <= 1'b0;
      pinSync  <= 1'b0;
      pinLast  <= 1'b0;
    end
    else if (clkEn)
    begin
      haltMeta <= debugHalt;
      haltSync <= haltMeta;
      pinMeta  <= capCmpPinZero;
      pinSync  <= pinMeta;
      pinLast  <= pinSync;
    end
  end

  // rtc divider: one tick per RTC_DIV rising edges of the capture clock
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rtcDiv  <= 16'h0000;
      rtcTick <= 1'b0;
    end
    else if (clkEn)
    begin
      rtcTick <= 1'b0;
      if (!isRtc || !ctl[`GTM_CTL_EN])
        rtcDiv <= 16'h0000;
      else if (pinSync && !pinLast)
      begin
        if (rtcDiv == 16'(RTC_DIV - 1))
        begin
          rtcDiv  <= 16'h0000;
          rtcTick <= 1'b1;
        end
        else
          rtcDiv <= rtcDiv + 16'h0001;
      end
    end
  end

  // register read mux
  always_comb
  begin
    case (avReq.address)
      `GTM_CFG_OFS:    rdMux = {29'h0000_0000, cfg};
      `GTM_AMODE_OFS:  rdMux = {30'h0000_0000, modeFld[0]};
      `GTM_BMODE_OFS:  rdMux = {30'h0000_0000, modeFld[1]};
      `GTM_CTL_OFS:    rdMux = {16'h0000, ctl};
      `GTM_IMR_OFS:    rdMux = {16'h0000, imr};
      `GTM_RIS_OFS:    rdMux = {16'h0000, ris};
      `GTM_MIS_OFS:    rdMux = {16'h0000, ris & imr};
      `GTM_AILR_OFS:   rdMux = is32 ? ilr : {16'h0000, ilr[0]};
      `GTM_BILR_OFS:   rdMux = {16'h0000, ilr[1]};
      `GTM_AMATCH_OFS: rdMux = is32 ? match : {16'h0000, match[0]};
      `GTM_BMATCH_OFS: rdMux = {16'h0000, match[1]};
      `GTM_APR_OFS:    rdMux = {24'h00_0000, pr[0]};
      `GTM_BPR_OFS:    rdMux = {24'h00_0000, pr[1]};
      `GTM_ACNT_OFS:   rdMux = is32 ? cnt : {16'h0000, cnt[0]};
      `GTM_BCNT_OFS:   rdMux = {16'h0000, cnt[1]};
      default:         rdMux = 32'h0000_0000;
    endcase
  end

  // avalon slave: waitrequest drops for one cycle per request
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avRsp.readdata    <= 32'h0000_0000;
      avRsp.waitrequest <= 1'b1;
    end
    else if (clkEn)
    begin
      if (avRsp.waitrequest && (avReq.read || avReq.write))
      begin
        avRsp.waitrequest <= 1'b0;
        avRsp.readdata    <= avReq.read ? rdMux : 32'h0000_0000;
      end
      else
      begin
        avRsp.waitrequest <= 1'b1;
      end
    end
  end

  // software-written configuration, load, match and prescale registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg     <= `GTM_CFG_RST;
      modeFld <= '0;
      imr     <= 16'h0000;
      ilr     <= {`GTM_CNT_RST, `GTM_CNT_RST};
      match   <= '0;
      pr      <= {`GTM_PSC_RST, `GTM_PSC_RST};
      ldPend  <= 2'b00;
    end
    else if (clkEn)
    begin
      ldPend <= 2'b00;
      if (wrNow)
      begin
        case (avReq.address)
          `GTM_CFG_OFS:    cfg        <= wrWord[2:0];
          `GTM_AMODE_OFS:  modeFld[0] <= wrWord[1:0];
          `GTM_BMODE_OFS:  modeFld[1] <= wrWord[1:0];
          `GTM_IMR_OFS:    imr        <= wrWord[15:0] & `GTM_INT_MASK;
          `GTM_AILR_OFS:
          begin
            if (is32)
              ilr <= wrWord;
            else
              ilr[0] <= wrWord[15:0];
            ldPend[0] <= 1'b1;
          end
          `GTM_BILR_OFS:
          begin
            ilr[1]    <= wrWord[15:0];
            ldPend[1] <= !is32;
          end
          `GTM_AMATCH_OFS:
          begin
            if (is32)
              match <= wrWord;
            else
              match[0] <= wrWord[15:0];
          end
          `GTM_BMATCH_OFS: match[1] <= wrWord[15:0];
          `GTM_APR_OFS:    pr[0]    <= wrWord[7:0];
          `GTM_BPR_OFS:    pr[1]    <= wrWord[7:0];
          default:         cfg      <= cfg;
        endcase
      end
    end
  end

  // split mode: each half a 16-bit down-counter with prescaler
  for (genvar h = 0; h < 2; h++)
  begin : g_half
    always_comb
    begin
      splitCnt[h] = cnt[h];
      splitPsc[h] = psc[h];
      splitTo[h]  = 1'b0;
      if (ldPend[h])
        splitCnt[h] = ilr[h];
      else if (ctl[h*`GTM_HALF_STRIDE + `GTM_CTL_EN] &&
               !(ctl[h*`GTM_HALF_STRIDE + `GTM_CTL_STALL] && haltSync))
      begin
        if (psc[h] != 8'h00)
          splitPsc[h] = psc[h] - 8'h01;
        else
        begin
          splitPsc[h] = pr[h];
          if (cnt[h] == 16'h0000)
          begin
            splitCnt[h] = ilr[h];
            splitTo[h]  = 1'b1;
          end
          else
            splitCnt[h] = cnt[h] - 16'h0001;
        end
      end
    end
  end

  // counter next value by mode
  always_comb
  begin
    next_cnt = cnt;
    next_psc = psc;
    toEv     = 2'b00;
    rtcEv    = 1'b0;
    if (isRtc)
    begin
      if (!rtcSeen)
        next_cnt = `GTM_RTC_FIRST;
      else if (ctl[`GTM_CTL_EN] && rtcTick && !rtcStall)
      begin
        if (cnt == match)
        begin
          next_cnt = 32'h0000_0000;
          rtcEv    = 1'b1;
        end
        else
          next_cnt = cnt + 32'h0000_0001;
      end
    end
    else if (is32)
    begin
      if (ldPend[0])
        next_cnt = ilr;
      else if (ctl[`GTM_CTL_EN] && !(ctl[`GTM_CTL_STALL] && haltSync))
      begin
        if (cnt == 32'h0000_0000)
        begin
          next_cnt = ilr;
          toEv[0]  = 1'b1;
        end
        else
          next_cnt = cnt - 32'h0000_0001;
      end
    end
    else
    begin
      for (int h = 0; h < 2; h++)
      begin
        next_cnt[h] = splitCnt[h];
        next_psc[h] = splitPsc[h];
        toEv[h]     = splitTo[h];
      end
    end
  end

  // counters, prescalers and first-rtc-entry marker
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt     <= {`GTM_CNT_RST, `GTM_CNT_RST};
      psc     <= {`GTM_PSC_RST, `GTM_PSC_RST};
      rtcSeen <= 1'b0;
    end
    else if (clkEn)
    begin
      cnt <= next_cnt;
      psc <= next_psc;
      if (isRtc)
        rtcSeen <= 1'b1;
    end
  end

  // control register: software write, hardware clears enable on one-shot
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ctl <= 16'h0000;
    else if (clkEn)
    begin
      if (wrNow && avReq.address == `GTM_CTL_OFS)
        ctl <= wrWord[15:0] & `GTM_CTL_MASK;
      else
      begin
        for (int h = 0; h < 2; h++)
        begin
          if (toEv[h] && modeFld[h] == GTM_MODE_ONESHOT)
            ctl[h*`GTM_HALF_STRIDE + `GTM_CTL_EN] <= 1'b0;
        end
      end
    end
  end

  // raw status next value: a set in the clearing cycle wins
  always_comb
  begin
    next_ris = ris;
    if (wrNow && avReq.address == `GTM_ICR_OFS)
      next_ris = ris & ~wrWord[15:0];
    next_ris[`GTM_INT_TO] = next_ris[`GTM_INT_TO] | toEv[0];
    next_ris[`GTM_HALF_STRIDE + `GTM_INT_TO] =
      next_ris[`GTM_HALF_STRIDE + `GTM_INT_TO] | toEv[1];
    next_ris[`GTM_INT_RTC] = next_ris[`GTM_INT_RTC] | rtcEv;
  end

  // status, interrupt line and trigger pulse
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ris        <= 16'h0000;
      irq        <= 1'b0;
      adcTrigger <= 1'b0;
    end
    else if (clkEn)
    begin
      ris        <= next_ris;
      irq        <= |(next_ris & imr);
      adcTrigger <= (toEv[0] && ctl[`GTM_CTL_OTE]) ||
                    (toEv[1] && ctl[`GTM_HALF_STRIDE + `GTM_CTL_OTE]);
    end
  end

endmodule

// [testbench/gtm_timer_props.sv]
// concurrent checks on the ports of the general timer
`include "gtm_map.svh"
module gtm_timer_props
  import gtm_pkg::*;
#(
  parameter int RTC_DIV = 4
)(
  // clock, enable and reset
  input wire logic       ref_clk,
  input wire logic       clkEn,
  input wire logic       resetn,
  // register bus
  input wire gtm_avreq_s avReq,
  input wire gtm_avrsp_s avRsp,
  // pins and outputs
  input wire logic       capCmpPinZero,
  input wire logic       debugHalt,
  input wire logic       adcTrigger,
  input wire logic       irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // accepted write to a register that can drop the interrupt
  logic clrHit;
  assign clrHit = avReq.write && !avRsp.waitrequest &&
    (avReq.address == `GTM_ICR_OFS || avReq.address == `GTM_IMR_OFS);

  property p_resetQuiet;
    disable iff (1'b0) !resetn |-> avRsp.waitrequest && !irq && !adcTrigger;
  endproperty
  a_resetQuiet: assert property (p_resetQuiet)
    else $error("outputs active during reset");

  property p_answer;
    (avReq.read || avReq.write) && avRsp.waitrequest && clkEn |=> !avRsp.waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered on next edge");

  property p_oneLow;
    !avRsp.waitrequest |=> avRsp.waitrequest;
  endproperty
  a_oneLow: assert property (p_oneLow)
    else $error("waitrequest low longer than one cycle");

  property p_rdHold;
    $changed(avRsp.readdata) |-> !avRsp.waitrequest;
  endproperty
  a_rdHold: assert property (p_rdHold)
    else $error("read data moved outside an answer");

  property p_zeroRead;
    !avRsp.waitrequest && $past(avReq.read) &&
      ($past(avReq.address) inside {`GTM_ICR_OFS, 8'h40}) |-> avRsp.readdata == 32'h0;
  endproperty
  a_zeroRead: assert property (p_zeroRead)
    else $error("clear register or hole read nonzero");

  property p_cfgRsvd;
    !avRsp.waitrequest && $past(avReq.read) && $past(avReq.address) == `GTM_CFG_OFS
      |-> avRsp.readdata[31:3] == 29'h0;
  endproperty
  a_cfgRsvd: assert property (p_cfgRsvd)
    else $error("configuration reserved bits nonzero");

  property p_trigPulse;
    adcTrigger |=> !adcTrigger;
  endproperty
  a_trigPulse: assert property (p_trigPulse)
    else $error("trigger longer than one cycle");

  property p_irqFall;
    $fell(irq) |-> $past(clrHit) || $past(clrHit, 2);
  endproperty
  a_irqFall: assert property (p_irqFall)
    else $error("interrupt fell without a clear");
endmodule

bind gtm_timer gtm_timer_props #(.RTC_DIV(RTC_DIV)) u_props (
  .ref_clk(ref_clk), .clkEn(clkEn), .resetn(resetn), .avReq(avReq), .avRsp(avRsp),
  .capCmpPinZero(capCmpPinZero), .debugHalt(debugHalt), .adcTrigger(adcTrigger), .irq(irq));

// [testbench/gtm_rtc_src.sv]
// slow rtc input clock source, rate scaled down for simulation
module gtm_rtc_src #(
  parameter int HALF = 8
)(
  // clock and control
  input  wire logic ref_clk,
  input  wire logic run,
  // rtc input pin
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial pin = 1'b0;
  // toggle every HALF cycles while running, rest low
  always @(posedge ref_clk)
  begin
    if (!run)
    begin
      cnt <= 0;
      pin <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      pin <= !pin;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

// [testbench/gtm_timer_tb_top.sv]
// self-checking bench of the general timer
`include "gtm_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module gtm_timer_tb_top
  import gtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b1;
  logic        clkEn = 1'b1;
  logic        debugHalt = 1'b0;
  logic        rtcRun = 1'b0;
  logic        capPin;
  gtm_avreq_s  avReq = '0;
  gtm_avrsp_s  avRsp;
  logic        adcTrig;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] held;
  int          n_errors = 0;
  int          tests_run = 0;
  int          nTrig = 0;
  int          nTrig0;
  int          w;

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  gtm_timer #(.RTC_DIV(4)) dut (
    .ref_clk(ref_clk), .clkEn(clkEn), .resetn(resetn), .avReq(avReq), .avRsp(avRsp),
    .capCmpPinZero(capPin), .debugHalt(debugHalt), .adcTrigger(adcTrig), .irq(irq));

  gtm_rtc_src #(.HALF(8)) u_src (.ref_clk(ref_clk), .run(rtcRun), .pin(capPin));

  // count trigger pulses
  always @(posedge ref_clk) nTrig <= nTrig + int'(adcTrig === 1'b1);

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one bus access, held until waitrequest is sampled low
  task automatic busIo(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avReq <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avRsp.waitrequest !== 1'b0);
    rd = avRsp.readdata;
    `CHK(n, 2)
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    busIo(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // wait for trigger or interrupt under a cycle limit
  task automatic waitHi(input logic useIrq, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while ((useIrq ? irq : adcTrig) !== 1'b1 && n < lim);
    `CHK(n < lim, 1'b1)
  endtask

  // watchdog
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end

  // test sequence
  initial
  begin
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rdChk(`GTM_CFG_OFS, 32'h0);
    rdChk(`GTM_CTL_OFS, 32'h0);
    rdChk(`GTM_RIS_OFS, 32'h0);
    rdChk(`GTM_ICR_OFS, 32'h0);
    rdChk(8'h40, 32'h0);
    rdChk(`GTM_ACNT_OFS, 32'hFFFF_FFFF);
    rdChk(`GTM_BILR_OFS, 32'h0000_FFFF);
    rdChk(`GTM_APR_OFS, 32'h0);
    rdChk(`GTM_BPR_OFS, 32'h0);
    $display("test reset done");
    busIo(1'b1, `GTM_AILR_OFS, 32'h0003_0010);
    rdChk(`GTM_BILR_OFS, 32'h0000_0003);
    rdChk(`GTM_ACNT_OFS, 32'h0003_0010);
    busIo(1'b1, `GTM_AILR_OFS, 32'h0000_0020);
    busIo(1'b1, `GTM_AMODE_OFS, 32'h1);
    busIo(1'b1, `GTM_BMODE_OFS, 32'h2);
    busIo(1'b1, `GTM_IMR_OFS, 32'h1);
    busIo(1'b1, `GTM_CTL_OFS, 32'h21);
    waitHi(1'b0, 100, w);
    repeat (4) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    rdChk(`GTM_MIS_OFS, 32'h1);
    rdChk(`GTM_CTL_OFS, 32'h20);
    rdChk(`GTM_ACNT_OFS, 32'h20);
    busIo(1'b1, `GTM_ICR_OFS, 32'h1);
    rdChk(`GTM_RIS_OFS, 32'h0);
    `CHK(irq, 1'b0)
    $display("test oneshot done");
    busIo(1'b1, `GTM_IMR_OFS, 32'h0);
    busIo(1'b1, `GTM_AMODE_OFS, 32'h2);
    busIo(1'b1, `GTM_AILR_OFS, 32'h10);
    nTrig0 = nTrig;
    busIo(1'b1, `GTM_CTL_OFS, 32'h1);
    repeat (60) @(posedge ref_clk);
    `CHK(nTrig, nTrig0)
    rdChk(`GTM_RIS_OFS, 32'h1);
    rdChk(`GTM_MIS_OFS, 32'h0);
    `CHK(irq, 1'b0)
    rdChk(`GTM_CTL_OFS, 32'h1);
    busIo(1'b1, `GTM_AILR_OFS, 32'h1000);
    busIo(1'b0, `GTM_ACNT_OFS, 32'h0);
    `CHK(rd <= 32'h1000 && rd > 32'hFF0, 1'b1)
    debugHalt <= 1'b1;
    busIo(1'b1, `GTM_CTL_OFS, 32'h3);
    repeat (4) @(posedge ref_clk);
    busIo(1'b0, `GTM_ACNT_OFS, 32'h0);
    held = rd;
    repeat (10) @(posedge ref_clk);
    rdChk(`GTM_ACNT_OFS, held);
    debugHalt <= 1'b0;
    repeat (6) @(posedge ref_clk);
    busIo(1'b0, `GTM_ACNT_OFS, 32'h0);
    `CHK(rd < held, 1'b1)
    // clock enable low freezes the running count
    held = rd;
    clkEn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    clkEn <= 1'b1;
    busIo(1'b0, `GTM_ACNT_OFS, 32'h0);
    `CHK(rd, held - 32'h3)
    busIo(1'b1, `GTM_CTL_OFS, 32'h0);
    busIo(1'b1, `GTM_ICR_OFS, 32'h1);
    $display("test periodic done");
    // split mode: high half alone, periodic, with trigger
    busIo(1'b1, `GTM_CFG_OFS, 32'h4);
    busIo(1'b1, `GTM_BILR_OFS, 32'h5);
    rdChk(`GTM_BCNT_OFS, 32'h5);
    rdChk(`GTM_AILR_OFS, 32'h1000);
    busIo(1'b1, `GTM_CTL_OFS, 32'h2100);
    waitHi(1'b0, 50, w);
    rdChk(`GTM_RIS_OFS, 32'h100);
    rdChk(`GTM_CTL_OFS, 32'h2100);
    busIo(1'b1, `GTM_CTL_OFS, 32'h0);
    busIo(1'b1, `GTM_ICR_OFS, 32'h100);
    $display("test split done");
    busIo(1'b1, `GTM_CFG_OFS, 32'h1);
    rdChk(`GTM_ACNT_OFS, 32'h1);
    busIo(1'b1, `GTM_AMATCH_OFS, 32'h3);
    busIo(1'b1, `GTM_IMR_OFS, 32'h8);
    debugHalt <= 1'b1;
    rtcRun <= 1'b1;
    busIo(1'b1, `GTM_CTL_OFS, 32'h13);
    waitHi(1'b1, 260, w);
    `CHK(w > 120, 1'b1)
    rdChk(`GTM_RIS_OFS, 32'h8);
    rdChk(`GTM_ACNT_OFS, 32'h0);
    busIo(1'b1, `GTM_ICR_OFS, 32'h8);
    rdChk(`GTM_MIS_OFS, 32'h0);
    `CHK(irq, 1'b0)
    $display("test rtc done");
    report_and_stop();
  end
endmodule
